// ==== aac_calib_step.v ====
// Purpose: auxiliary converter calibration words and first step config
// Assumes: AXI4-Lite master, conversion datapath on the same clock
// Notes:   one step only; further steps and mode control live elsewhere
//
// Design decision made here: register access over AXI4-Lite.
`include "aac_regs.vh"

module aac_calib_step (
    // clock and reset
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire        i_clk_en,
    // axi4-lite write address and data
    input  wire [11:0] i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    // axi4-lite write response
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    // axi4-lite read
    input  wire [11:0] i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // conversion datapath
    input  wire        i_conv_done,
    output reg         o_conv_start,
    output reg         o_step_active,
    output reg  [1:0]  o_gain_setting,
    output reg         o_offset_half_lsb,
    output reg  [3:0]  o_pos_select,
    output reg         o_neg_select,
    output reg         o_neg_auto,
    output reg  [15:0] o_offset_word,
    output reg  [15:0] o_gain_word
);

    localparam [3:0] ST_IDLE   = 4'h1;
    localparam [3:0] ST_SETTLE = 4'h2;
    localparam [3:0] ST_CONV   = 4'h4;
    localparam [3:0] ST_WAIT   = 4'h8;

    reg [15:0] offset_reg;
    reg [15:0] gain_reg;
    reg [15:0] step_reg;
    reg [2:0]  delay_reg;
    reg        launch_reg;
    reg        skipped_reg;
    reg        done_reg;
    reg [3:0]  state_reg;
    reg [11:0] aw_addr_reg;
    reg        aw_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;
    reg        w_held_reg;

    // timer busy is left open: the sequencer state already tells the same
    wire       tmr_done;
    wire       tmr_start;
    wire       tmr_abort;
    wire       do_write;
    wire [9:0] wr_idx;
    wire [9:0] rd_idx;
    wire       step_en;
    wire [3:0] pos_code;

    assign do_write  = aw_held_reg & w_held_reg & ~o_bvalid;
    assign wr_idx    = aw_addr_reg[11:2];
    assign rd_idx    = i_araddr[11:2];
    assign step_en   = step_reg[`AAC_STEP_EN_BIT];
    assign pos_code  = step_reg[`AAC_STEP_POS_HI:`AAC_STEP_POS_LO];
    assign tmr_start = launch_reg & step_en;
    assign tmr_abort = launch_reg & ~step_en;

    // byte-lane merge of the low half word
    function [15:0] merge16;
        input [15:0] old_val;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge16[7:0]  = strb[0] ? data[7:0] : old_val[7:0];
            merge16[15:8] = strb[1] ? data[15:8] : old_val[15:8];
        end
    endfunction

    // true when a word index names a mapped register
    function mapped;
        input [9:0] idx;
        begin
            mapped = (idx == `AAC_IDX_OFFSET) || (idx == `AAC_IDX_GAIN) ||
                     (idx == `AAC_IDX_STEP0) || (idx == `AAC_IDX_CTRL) ||
                     (idx == `AAC_IDX_STATUS);
        end
    endfunction

    // gain field decode, 10 and 11 both mean x4
    function [1:0] gain_decode;
        input [1:0] code;
        begin
            case (code)
                2'h0:    gain_decode = `AAC_GAIN_X1;
                2'h1:    gain_decode = `AAC_GAIN_X2;
                default: gain_decode = `AAC_GAIN_X4;
            endcase
        end
    endfunction

    aac_settle_timer u_settle (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_clk_en     (i_clk_en),
        .i_start      (tmr_start),
        .i_abort      (tmr_abort),
        .i_delay_code (delay_reg),
        .o_busy       (),
        .o_done       (tmr_done)
    );

    // write channels are taken independently; the write lands once both are held
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_awready   <= 1'b0;
            o_wready    <= 1'b0;
            o_bvalid    <= 1'b0;
            o_bresp     <= `AAC_RESP_OKAY;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            offset_reg  <= `AAC_RST_OFFSET;
            gain_reg    <= `AAC_RST_GAIN;
            step_reg    <= `AAC_RST_STEP0;
            delay_reg   <= `AAC_RST_DELAY;
            launch_reg  <= 1'b0;
        end else if (i_clk_en) begin
            launch_reg <= 1'b0;
            o_awready  <= ~aw_held_reg & ~(o_awready & i_awvalid);
            o_wready   <= ~w_held_reg & ~(o_wready & i_wvalid);
            if (o_awready & i_awvalid) begin
                aw_addr_reg <= i_awaddr;
                aw_held_reg <= 1'b1;
            end
            if (o_wready & i_wvalid) begin
                w_data_reg <= i_wdata;
                w_strb_reg <= i_wstrb;
                w_held_reg <= 1'b1;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                o_awready   <= 1'b0;
                o_wready    <= 1'b0;
                o_bvalid    <= 1'b1;
                o_bresp     <= mapped(wr_idx) ? `AAC_RESP_OKAY : `AAC_RESP_SLVERR;
                case (wr_idx)
                    `AAC_IDX_OFFSET: begin
                        offset_reg <= merge16(offset_reg, w_data_reg, w_strb_reg);
                    end
                    `AAC_IDX_GAIN: begin
                        gain_reg <= merge16(gain_reg, w_data_reg, w_strb_reg);
                    end
                    `AAC_IDX_STEP0: begin
                        // reserved bits never store, so they always read back zero
                        step_reg <= merge16(step_reg, w_data_reg, w_strb_reg)
                                    & `AAC_STEP_WMASK;
                    end
                    `AAC_IDX_CTRL: begin
                        if (w_strb_reg[1]) begin
                            delay_reg <= w_data_reg[`AAC_CTRL_DLY_HI:`AAC_CTRL_DLY_LO];
                        end
                        if (w_strb_reg[0]) begin
                            launch_reg <= w_data_reg[`AAC_CTRL_LAUNCH_BIT];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (o_bvalid & i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one word per request, answered the cycle after it is taken
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `AAC_RESP_OKAY;
        end else if (i_clk_en) begin
            o_arready <= ~o_rvalid & ~(o_arready & i_arvalid);
            if (o_arready & i_arvalid) begin
                o_arready <= 1'b0;
                o_rvalid  <= 1'b1;
                o_rresp   <= mapped(rd_idx) ? `AAC_RESP_OKAY : `AAC_RESP_SLVERR;
                case (rd_idx)
                    `AAC_IDX_OFFSET: o_rdata <= {16'h0000, offset_reg};
                    `AAC_IDX_GAIN:   o_rdata <= {16'h0000, gain_reg};
                    `AAC_IDX_STEP0:  o_rdata <= {16'h0000, step_reg};
                    `AAC_IDX_CTRL:   o_rdata <= {21'h000000, delay_reg, 8'h00};
                    `AAC_IDX_STATUS: o_rdata <= {28'h0000000, done_reg, skipped_reg,
                                                 state_reg == ST_WAIT || state_reg == ST_CONV,
                                                 state_reg != ST_IDLE};
                    default:         o_rdata <= 32'h00000000;
                endcase
            end else if (o_rvalid & i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // step sequencer; a launch always aborts an ongoing step and restarts it only when the step is enabled
    always @(posedge i_clock) begin
        if (i_rst) begin
            state_reg         <= ST_IDLE;
            skipped_reg       <= 1'b0;
            done_reg          <= 1'b0;
            o_conv_start      <= 1'b0;
            o_step_active     <= 1'b0;
            o_gain_setting    <= `AAC_GAIN_X1;
            o_offset_half_lsb <= 1'b0;
            o_pos_select      <= 4'h0;
            o_neg_select      <= 1'b0;
            o_neg_auto        <= 1'b0;
            o_offset_word     <= `AAC_RST_OFFSET;
            o_gain_word       <= `AAC_RST_GAIN;
        end else if (i_clk_en) begin
            o_conv_start  <= 1'b0;
            o_offset_word <= offset_reg;
            o_gain_word   <= gain_reg;
            case (state_reg)
                ST_IDLE: begin
                end
                ST_SETTLE: begin
                    if (tmr_done) begin
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // selections are applied from here until the conversion ends
                    o_conv_start      <= 1'b1;
                    o_step_active     <= 1'b1;
                    o_gain_setting    <= gain_decode(
                        step_reg[`AAC_STEP_GAIN_HI:`AAC_STEP_GAIN_LO]);
                    o_offset_half_lsb <= step_reg[`AAC_STEP_GAIN_HI:`AAC_STEP_GAIN_LO]
                                         != 2'h0;
                    o_pos_select      <= pos_code;
                    o_neg_auto        <= pos_code >= `AAC_POS_FIRST_AUTO;
                    // automatic codes (8 and up: sensor, short, dac, supply, and 0xC to 0xF) ignore the negative bit
                    o_neg_select      <= (pos_code < `AAC_POS_FIRST_AUTO) &
                                         step_reg[`AAC_STEP_NEG_BIT];
                    state_reg         <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (i_conv_done) begin
                        state_reg     <= ST_IDLE;
                        done_reg      <= 1'b1;
                        o_step_active <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            if (launch_reg) begin
                done_reg      <= 1'b0;
                o_step_active <= 1'b0;
                o_conv_start  <= 1'b0;
                if (step_en) begin
                    state_reg   <= ST_SETTLE;
                    skipped_reg <= 1'b0;
                end else begin
                    state_reg   <= ST_IDLE;
                    skipped_reg <= 1'b1;
                    done_reg    <= 1'b1;
                end
            end
        end
    end

endmodule // aac_calib_step

// ==== aac_regs.vh ====
// Purpose: register map, field layout, reset values and timing counts
// Assumes: 32-bit AXI4-Lite words, byte address = 4 x register index
// Notes:   definitions only
`ifndef AAC_REGS_VH
`define AAC_REGS_VH

`define AAC_IDX_OFFSET      10'h08E
`define AAC_IDX_GAIN        10'h08F
`define AAC_IDX_STEP0       10'h090
`define AAC_IDX_CTRL        10'h094
`define AAC_IDX_STATUS      10'h095

`define AAC_RST_OFFSET      16'h0000
`define AAC_RST_GAIN        16'h0000
`define AAC_RST_STEP0       16'h0000
`define AAC_RST_DELAY       3'h0

`define AAC_STEP_EN_BIT     15
`define AAC_STEP_GAIN_HI    14
`define AAC_STEP_GAIN_LO    13
`define AAC_STEP_NEG_BIT    4
`define AAC_STEP_POS_HI     3
`define AAC_STEP_POS_LO     0
`define AAC_STEP_WMASK      16'hE01F

`define AAC_CTRL_LAUNCH_BIT 0
`define AAC_CTRL_DLY_HI     10
`define AAC_CTRL_DLY_LO     8

`define AAC_STAT_BUSY_BIT   0
`define AAC_STAT_CONV_BIT   1
`define AAC_STAT_SKIP_BIT   2
`define AAC_STAT_DONE_BIT   3

`define AAC_GAIN_X1         2'h0
`define AAC_GAIN_X2         2'h1
`define AAC_GAIN_X4         2'h2

`define AAC_POS_FIRST_AUTO  4'h8
`define AAC_POS_TEMP        4'h8
`define AAC_POS_SHORT       4'h9
`define AAC_POS_TEST_DAC    4'hA
`define AAC_POS_SUPPLY_DIV4 4'hB

`define AAC_DLY_MIN_CYC     13'h0010
`define AAC_DLY_BASE_CYC    13'h0040

`define AAC_RESP_OKAY       2'h0
`define AAC_RESP_SLVERR     2'h2

`endif

// ==== aac_settle_timer.v ====
// Purpose: settling delay timer ahead of a sequence step conversion
// Assumes: i_clock is the converter master clock
// Notes:   restart while counting reloads the count
`include "aac_regs.vh"

module aac_settle_timer (
    // clock and reset
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire        i_clk_en,
    // control
    input  wire        i_start,
    input  wire        i_abort,
    input  wire [2:0]  i_delay_code,
    // status
    output reg         o_busy,
    output reg         o_done
);

    reg [12:0] count_reg;

    // 000 -> 16 cycles, then 64 doubling up to 4096
    function [12:0] delay_cycles;
        input [2:0] code;
        begin
            if (code == 3'h0) begin
                delay_cycles = `AAC_DLY_MIN_CYC;
            end else begin
                delay_cycles = `AAC_DLY_BASE_CYC << (code - 3'h1);
            end
        end
    endfunction

    always @(posedge i_clock) begin
        if (i_rst) begin
            count_reg <= 13'h0000;
            o_busy    <= 1'b0;
            o_done    <= 1'b0;
        end else if (i_clk_en) begin
            o_done <= 1'b0;
            if (i_abort) begin
                o_busy <= 1'b0;
            end else if (i_start) begin
                count_reg <= delay_cycles(i_delay_code) - 13'h0001;
                o_busy    <= 1'b1;
            end else if (o_busy) begin
                if (count_reg == 13'h0000) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    count_reg <= count_reg - 13'h0001;
                end
            end
        end
    end

endmodule // aac_settle_timer

// ==== aac_calib_step_monitor.sv ====
// Purpose: port checker for aac_calib_step
// Assumes: one clock, sync reset, clock enable may drop at any time
// Notes:   bound to every instance of the block
module aac_calib_step_monitor (
    // clock and reset
    input logic        i_clock,
    input logic        i_rst,
    input logic        i_clk_en,
    // bus side
    input logic        i_awvalid,
    input logic        o_awready,
    input logic        o_bvalid,
    input logic        i_bready,
    input logic        o_rvalid,
    input logic        i_rready,
    input logic [31:0] o_rdata,
    input logic [1:0]  o_bresp,
    // datapath side
    input logic        i_conv_done,
    input logic        o_conv_start,
    input logic        o_step_active,
    input logic [1:0]  o_gain_setting,
    input logic        o_offset_half_lsb,
    input logic [3:0]  o_pos_select,
    input logic        o_neg_select,
    input logic        o_neg_auto
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // cycles since last write address take; saturates
    logic [7:0] gap_reg;
    always @(posedge i_clock) begin
        if (i_rst || (i_awvalid && o_awready)) gap_reg <= 8'h00;
        else if (gap_reg != 8'hFF) gap_reg <= gap_reg + 8'h01;
    end
    a_settle_min_gap: assert property (o_conv_start |-> gap_reg >= 8'h10)
        else $error("conversion started before settling");
    a_gain_code_legal: assert property (o_conv_start |-> o_gain_setting != 2'h3)
        else $error("gain setting out of range");
    a_offset_half_step: assert property (o_conv_start |->
        o_offset_half_lsb == (o_gain_setting != 2'h0))
        else $error("offset step size wrong");
    a_neg_auto_flag: assert property (o_conv_start |-> o_neg_auto == o_pos_select[3])
        else $error("auto negative flag wrong");
    a_neg_forced_off: assert property (o_conv_start && o_neg_auto |-> !o_neg_select)
        else $error("negative select not ignored");
    a_start_with_active: assert property (o_conv_start |-> o_step_active)
        else $error("start without active step");
    a_active_ends: assert property (o_step_active && i_conv_done && i_clk_en |=>
        !o_step_active)
        else $error("step stays active after done");
    a_freeze_holds: assert property (!i_clk_en |=> $stable(o_step_active) &&
        $stable(o_awready) && $stable(o_pos_select))
        else $error("state moved while clock enable low");
    a_sel_held: assert property (o_step_active && $past(o_step_active) |->
        $stable(o_pos_select) && $stable(o_gain_setting) && $stable(o_neg_select))
        else $error("selection changed mid conversion");
    a_bvalid_held: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_rvalid_held: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    c_conv: cover property (o_conv_start);
    c_auto: cover property (o_conv_start && o_neg_auto);
    c_slverr: cover property (o_bvalid && o_bresp == 2'h2);
endmodule // aac_calib_step_monitor

bind aac_calib_step aac_calib_step_monitor aac_calib_step_monitor_inst (
    .i_clock, .i_rst, .i_clk_en, .i_awvalid, .o_awready, .o_bvalid, .i_bready,
    .o_rvalid, .i_rready, .o_rdata, .o_bresp, .i_conv_done, .o_conv_start,
    .o_step_active, .o_gain_setting, .o_offset_half_lsb, .o_pos_select,
    .o_neg_select, .o_neg_auto
);

// ==== tb.sv ====
// Purpose: self-checking bench for aac_calib_step
// Assumes: clock enable driven by the bench, full write strobes
// Notes:   register model kept in plain ints
`include "aac_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clock, i_rst, i_awvalid, i_wvalid, i_bready;
    logic        i_arvalid, i_rready, i_conv_done, i_clk_en;
    logic [11:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata;
    wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire  [1:0]  o_bresp, o_rresp, o_gain_setting;
    wire  [31:0] o_rdata;
    wire         o_conv_start, o_step_active, o_offset_half_lsb;
    wire  [3:0]  o_pos_select;
    wire         o_neg_select, o_neg_auto;
    wire  [15:0] o_offset_word, o_gain_word;
    int          errors, cmp_count, ofs, gn, stp, n, d, g, c;
    int          exp_q[$];
    localparam logic [11:0] A_OFS = {`AAC_IDX_OFFSET, 2'h0};
    localparam logic [11:0] A_GN = {`AAC_IDX_GAIN, 2'h0};
    localparam logic [11:0] A_STP = {`AAC_IDX_STEP0, 2'h0};
    localparam logic [11:0] A_CTL = {`AAC_IDX_CTRL, 2'h0};
    localparam logic [11:0] A_STA = {`AAC_IDX_STATUS, 2'h0};

    aac_calib_step aac_calib_step_inst (
        .i_clock, .i_rst, .i_clk_en, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
        .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
        .o_rvalid, .i_rready, .i_conv_done, .o_conv_start, .o_step_active,
        .o_gain_setting, .o_offset_half_lsb, .o_pos_select, .o_neg_select,
        .o_neg_auto, .o_offset_word, .o_gain_word
    );

    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] dat, input logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge i_clock);
        i_awaddr <= a;
        i_wdata <= dat;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge i_clock);
            if (i_awvalid && o_awready) begin
                aw = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
        do @(posedge i_clock); while (o_bvalid !== 1'b1);
        i_bready <= 1'b0;
        chk(o_bresp, r);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge i_clock);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do @(posedge i_clock); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        do @(posedge i_clock); while (o_rvalid !== 1'b1);
        i_rready <= 1'b0;
        chk(o_rdata, e);
        chk(o_rresp, r);
    endtask

    task automatic final_report;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // the whole run is well under this span; reaching it means a hang
    initial begin
        repeat (40000) @(posedge i_clock);
        errors++;
        final_report;
    end

    initial begin
        {i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h20;
        {i_awaddr, i_araddr, i_wdata, i_conv_done} = 57'h0;
        i_clk_en = 1'b1;
        errors = 0;
        cmp_count = 0;
        n = $urandom(99);
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(A_OFS, 32'h0, 2'h0);
        rd(A_GN, 32'h0, 2'h0);
        rd(A_STP, 32'h0, 2'h0);
        rd(12'h3FC, 32'h0, 2'h2);
        wr(12'h3FC, 32'h1234, 2'h2);
        repeat (4) begin
            ofs = $urandom & 32'hFFFF;
            gn = $urandom & 32'hFFFF;
            wr(A_OFS, $urandom & 32'hFFFF0000 | ofs, 2'h0);
            wr(A_GN, gn, 2'h0);
            exp_q.push_back(ofs);
            exp_q.push_back(gn);
            rd(A_OFS, exp_q.pop_front(), 2'h0);
            rd(A_GN, exp_q.pop_front(), 2'h0);
            chk(o_offset_word, ofs);
            chk(o_gain_word, gn);
        end
        wr(A_STP, 32'hFFFFFFFF, 2'h0);
        rd(A_STP, 32'hE01F, 2'h0);
        // every positive code and gain code, every delay code twice
        for (int k = 0; k < 16; k++) begin
            stp = 32'h8000 | ((k % 4) << 13) | (((k / 2) % 2) << 4) | k;
            c = k % 8;
            wr(A_STP, stp, 2'h0);
            wr(A_CTL, (c << 8) | 1, 2'h0);
            n = 0;
            while (o_conv_start !== 1'b1 && n < 5000) begin
                @(posedge i_clock);
                n++;
            end
            d = c ? (32 << c) : 16;
            g = (k % 4 > 1) ? 2 : k % 4;
            chk(n >= d && n <= d + 10, 1);
            chk(o_step_active, 1);
            chk(o_gain_setting, g);
            chk(o_offset_half_lsb, g != 0);
            chk(o_pos_select, k);
            chk(o_neg_select, ((k / 2) % 2) && k < 8);
            chk(o_neg_auto, k > 7);
            i_conv_done <= 1'b1;
            @(posedge i_clock);
            i_conv_done <= 1'b0;
            @(posedge i_clock);
            chk(o_step_active, 0);
        end
        // clock enable low freezes the settle count, so the wait grows by the frozen span
        wr(A_STP, 32'h8000, 2'h0);
        wr(A_CTL, 32'h1, 2'h0);
        i_clk_en <= 1'b0;
        repeat (40) @(posedge i_clock);
        i_clk_en <= 1'b1;
        n = 40;
        while (o_conv_start !== 1'b1 && n < 5000) begin
            @(posedge i_clock);
            n++;
        end
        chk(n >= 56 && n <= 66, 1);
        i_conv_done <= 1'b1;
        @(posedge i_clock);
        i_conv_done <= 1'b0;
        // long settle: busy shows, then a launch of a disabled step aborts it
        wr(A_CTL, 32'h701, 2'h0);
        rd(A_STA, 32'h1, 2'h0);
        rd(A_CTL, 32'h700, 2'h0);
        // disabled step: no conversion, skip and done flags set
        wr(A_STP, 32'h0001, 2'h0);
        wr(A_CTL, 32'h1, 2'h0);
        n = 0;
        repeat (200) begin
            @(posedge i_clock);
            if (o_conv_start === 1'b1) n++;
        end
        chk(n, 0);
        rd(A_STA, 32'hC, 2'h0);
        final_report;
    end
endmodule // tb
